// ==== pkg/ids_pkg.sv ====
// Package for the device select decoder: field positions, timing constants,
// carrier structs. Assumes a 100 MHz single clock.
package ids_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEL_LSB = 6;
  localparam int SEL_MSB = 11;
  localparam int SEL_W = 6;
  localparam int WORD_W = 18;
  localparam int NUM_CODES = 64;
  localparam int NUM_FIXED = 8;
  localparam int NUM_PULSES = 3;
  // Cable pulse widths in ns, and internal gate pulse width
  localparam int CABLE_SHORT_NS = 400;
  localparam int CABLE_LONG_NS = 1000;
  localparam int INT_PULSE_NS = 100;
  // Least widths round up to whole cycles
  localparam int CABLE_SHORT_CYC = (CABLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CABLE_LONG_CYC = (CABLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 7;

  // Three processor timing pulses: first, second, third (pulse numbers 1, 2, 4)
  typedef struct packed {
    logic third_timing_pulse;
    logic second_timing_pulse;
    logic first_timing_pulse;
  } ids_timing_t;

  // True and complement command pulses for every device code
  typedef struct packed {
    logic [NUM_CODES-1:0][NUM_PULSES-1:0] cmd;
    logic [NUM_CODES-1:0][NUM_PULSES-1:0] cmd_n;
  } ids_cmd_t;
endpackage

// ==== hw/ids_decoder.sv ====
// Device select decoder: turns timing pulses into per-device command pulses.
// Holds one channel per select code, each with its own pulse stretchers.
// Assumes instruction word and timing pulses arrive from another domain.
// Assumes the select field settles a few cycles before a timing pulse rises.
// Latency from a timing pin to its command is four clock edges.
// Functional notes
// - Bits 6 to 11 of the instruction word are the select code, in true and complement form.
// - Each channel holds one fixed code and opens its gate only when the field equals it.
// - A matching channel repeats each timing pulse that finds its gate and command idle as a true and complement command pulse.
// - Command index [code][k] is the pulse for code XX and timing pulse 1, 2 or 4.
// - Codes 00 to 07 form the fixed section; expandable channels cover the rest.
// - Cable pulses are 400 ns wide, or 1 us when the long option is chosen.
// - Internal gate pulses are 100 ns wide and end before the next cycle's pulse.
`timescale 1ns/1ns

// One select channel: fixed code compare and three pulse stretchers
module ids_chan #(
  parameter logic [5:0] CODE = 6'h00
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [5:0] i_sel,
  input wire logic [5:0] i_sel_n,
  input wire logic [2:0] i_gate,
  input wire logic i_long,
  output logic [2:0] o_cmd,
  output logic [2:0] o_cmd_n
);
  logic match;
  logic [2:0] cmd_q;
  logic [2:0] cmd_d;
  // Complement outputs get flops of their own, so both polarities leave a register
  logic [2:0] cmd_n_q;
  logic [2:0] cmd_n_d;
  // Width counters, one per timing pulse
  logic [2:0][6:0] cnt_q;
  logic [2:0][6:0] cnt_d;

  // Each bit is wired to its true or complement line per the fixed code;
  // a mismatch on any bit keeps the whole channel quiet
  always_comb begin
    match = 1'b1;
    for (int b = 0; b < 6; b++) begin
      match = match & (CODE[b] ? i_sel[b] : i_sel_n[b]);
    end
  end

  // Stretch each gated pulse to the cable width. The width option is taken
  // when the pulse starts; a gate that opens while the command is still out
  // is ignored, so a cable pulse is never cut short or doubled.
  always_comb begin
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    for (int k = 0; k < 3; k++) begin
      if (match && i_gate[k] && !cmd_q[k]) begin
        cmd_d[k] = 1'b1;
        cnt_d[k] = i_long ? 7'(ids_pkg::CABLE_LONG_CYC - 1)
                          : 7'(ids_pkg::CABLE_SHORT_CYC - 1);
      end else if (cmd_q[k]) begin
        if (cnt_q[k] == 7'h00) begin
          cmd_d[k] = 1'b0;
        end else begin
          cnt_d[k] = cnt_q[k] - 7'h01;
        end
      end
    end
    // Complement tracks the true pulse in the same cycle
    cmd_n_d = ~cmd_d;
  end

  // Registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmd_q <= 3'h0;
      cmd_n_q <= 3'h7; // Complement idles high
      cnt_q <= '0;
    end else begin
      cmd_q <= cmd_d;
      cmd_n_q <= cmd_n_d;
      cnt_q <= cnt_d;
    end
  end

  // Both polarities straight from flops
  assign o_cmd = cmd_q;
  assign o_cmd_n = cmd_n_q;
endmodule // ids_chan

// Top level: synchronisers, gate pulses, select code and one channel per code
module ids_decoder (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [ids_pkg::WORD_W-1:0] i_memory_buffer_word,
  input wire ids_pkg::ids_timing_t i_io_timing_pulse,
  input wire logic i_long_pulse,
  output ids_pkg::ids_cmd_t o_io_command_pulse
);
  // Synchroniser stages for the instruction word, timing pulses and width option
  logic [17:0] mb_s1_q;
  logic [17:0] mb_s2_q;
  logic [2:0] tp_s1_q;
  logic [2:0] tp_s2_q;
  logic [2:0] tp_s3_q;
  logic [2:0] tp_rise;
  logic long_s1_q;
  logic long_s2_q;
  // Internal gate pulses and their width counters
  logic [2:0] gate_q;
  logic [2:0] gate_d;
  logic [2:0][3:0] gcnt_q;
  logic [2:0][3:0] gcnt_d;
  // Select code in both polarities
  logic [5:0] sel_q;
  logic [5:0] sel_n_q;
  logic [5:0] sel_d;
  logic [5:0] sel_n_d;
  // Command pulses gathered from every channel
  logic [63:0][2:0] cmd;
  logic [63:0][2:0] cmd_n;

  // Two-flop synchronisers, plus a third stage for edge detection; only the
  // second stage of each pair is read by logic
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mb_s1_q <= 18'h00000;
      mb_s2_q <= 18'h00000;
      tp_s1_q <= 3'h0;
      tp_s2_q <= 3'h0;
      tp_s3_q <= 3'h0;
      long_s1_q <= 1'b0;
      long_s2_q <= 1'b0;
    end else begin
      mb_s1_q <= i_memory_buffer_word;
      mb_s2_q <= mb_s1_q;
      tp_s1_q <= i_io_timing_pulse;
      tp_s2_q <= tp_s1_q;
      tp_s3_q <= tp_s2_q;
      long_s1_q <= i_long_pulse;
      long_s2_q <= long_s1_q;
    end
  end

  // Rising edge of each synchronised timing pulse; the third stage idles low
  // like the pin, so release from reset makes no false edge
  assign tp_rise = tp_s2_q & ~tp_s3_q;

  // Internal gate pulse of fixed width from each rising timing pulse. An edge
  // that arrives while the gate is still open is dropped.
  always_comb begin
    gate_d = gate_q;
    gcnt_d = gcnt_q;
    for (int k = 0; k < 3; k++) begin
      if (tp_rise[k] && !gate_q[k]) begin
        gate_d[k] = 1'b1;
        gcnt_d[k] = 4'(ids_pkg::INT_PULSE_CYC - 1);
      end else if (gate_q[k]) begin
        if (gcnt_q[k] == 4'h0) begin
          gate_d[k] = 1'b0;
        end else begin
          gcnt_d[k] = gcnt_q[k] - 4'h1;
        end
      end
    end
  end

  // Select code in true and complement form. The instruction word is held
  // steady for several cycles before any timing pulse, so each bit may be
  // synchronised on its own without tearing the code.
  always_comb begin
    sel_d = 6'h00;
    sel_n_d = 6'h3F;
    // Bit 6 is the select MSB in the big-endian word numbering
    for (int b = 0; b < 6; b++) begin
      sel_d[5-b] = mb_s2_q[17-(ids_pkg::SEL_LSB+b)];
      sel_n_d[5-b] = ~mb_s2_q[17-(ids_pkg::SEL_LSB+b)];
    end
  end

  // Gate and select registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      gate_q <= 3'h0;
      gcnt_q <= '0;
      sel_q <= 6'h00;
      sel_n_q <= 6'h3F;
    end else begin
      gate_q <= gate_d;
      gcnt_q <= gcnt_d;
      sel_q <= sel_d;
      sel_n_q <= sel_n_d;
    end
  end

  // Fixed section: the standard devices on codes 00 to 07
  for (genvar c = 0; c < ids_pkg::NUM_FIXED; c++) begin : g_fixed
    ids_chan #(.CODE(6'(c))) u_chan (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_sel(sel_q),
      .i_sel_n(sel_n_q),
      .i_gate(gate_q),
      .i_long(long_s2_q),
      .o_cmd(cmd[c]),
      .o_cmd_n(cmd_n[c])
    );
  end

  // Expandable section: one channel for every remaining code
  for (genvar c = ids_pkg::NUM_FIXED; c < ids_pkg::NUM_CODES; c++) begin : g_exp
    ids_chan #(.CODE(6'(c))) u_chan (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_sel(sel_q),
      .i_sel_n(sel_n_q),
      .i_gate(gate_q),
      .i_long(long_s2_q),
      .o_cmd(cmd[c]),
      .o_cmd_n(cmd_n[c])
    );
  end

  // Command index [code][k]: k = 0, 1, 2 for timing pulses 1, 2 and 4
  assign o_io_command_pulse.cmd = cmd;
  assign o_io_command_pulse.cmd_n = cmd_n;
endmodule // ids_decoder

// ==== sim/ids_decoder_props.sv ====
// Checker for the device select decoder command outputs.
// Assumes one clock and an active-low reset on the top module.
`timescale 1ns/1ns
module ids_props (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [ids_pkg::WORD_W-1:0] i_memory_buffer_word,
  input wire ids_pkg::ids_timing_t i_io_timing_pulse,
  input wire logic i_long_pulse,
  input wire ids_pkg::ids_cmd_t o_io_command_pulse
);
  wire [191:0] c = o_io_command_pulse.cmd;
  wire [2:0] tp = i_io_timing_pulse;
  wire [191:0] sh = c >> (3 * i_memory_buffer_word[11:6]);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  a_compl_pair: assert property (o_io_command_pulse.cmd_n == ~c)
    else $error("complement output differs");
  a_rise_cause: assert property ($rose(|c) |-> $past(|tp, 4) || $past(|tp, 5))
    else $error("command without timing pulse");
  a_single_chan: assert property ($rose(|c) |-> $onehot(c))
    else $error("more than one command bit");
  a_field_match: assert property ($rose(|c) |-> |sh[2:0])
    else $error("command on wrong code");
  a_kind_match: assert property ($rose(|c) |-> sh[2:0] == ($past(tp, 4) | $past(tp, 5)))
    else $error("command on wrong pulse");
  a_short_width: assert property ($rose(|c) && !i_long_pulse |-> ##39 (|c) ##1 !(|c))
    else $error("short width wrong");
  a_long_width: assert property ($rose(|c) && i_long_pulse |-> ##99 (|c) ##1 !(|c))
    else $error("long width wrong");
  a_idle_quiet: assert property (!(|tp) [*8] |-> !$rose(|c))
    else $error("command while idle");
  // Main scenarios reached
  c_short: cover property ($rose(|c) && !i_long_pulse);
  c_long: cover property ($rose(|c) && i_long_pulse);
  c_fixed: cover property ($rose(|c[23:0]));
endmodule // ids_props

bind ids_decoder ids_props u_props (.i_mclk(i_mclk), .i_rstn(i_rstn),
  .i_memory_buffer_word(i_memory_buffer_word), .i_io_timing_pulse(i_io_timing_pulse),
  .i_long_pulse(i_long_pulse), .o_io_command_pulse(o_io_command_pulse));

// ==== sim/ids_periph.sv ====
// Peripheral model: latches the accumulator levels on a command pulse.
// Assumes the strobe comes from one decoder command bit.
`timescale 1ns/1ns
module ids_periph (
  input wire logic i_mclk,
  input wire logic i_strobe,
  input wire logic [17:0] i_buffered_accumulator_level,
  output logic [17:0] o_reg
);
  logic strobe_q;
  // Capture on the strobe's leading edge
  always_ff @(posedge i_mclk) begin
    strobe_q <= i_strobe;
    if (i_strobe && !strobe_q) o_reg <= i_buffered_accumulator_level;
  end
endmodule // ids_periph

// ==== sim/ids_decoder_tb.sv ====
// Testbench for the device select decoder with a peripheral model.
// Assumes a 100 MHz clock and inputs driven at the falling edge.
`timescale 1ns/1ns
module ids_decoder_tb;
  logic i_mclk, i_rstn, lng, strb;
  logic [17:0] wrd, acb, got;
  logic [15:0] lf = 16'h0958;
  logic [5:0] code;
  ids_pkg::ids_timing_t tp;
  ids_pkg::ids_cmd_t cmd;
  int errors, compares, cyc, h, o, k, wid;
  // Reference model: expected strobe level for each sample of a test
  int mdl_q[$];
  // Samples from raising a timing pin to its command: two sync stages, gate, channel
  localparam int LAT = 3;
  ids_decoder dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_memory_buffer_word(wrd),
    .i_io_timing_pulse(tp), .i_long_pulse(lng), .o_io_command_pulse(cmd));
  ids_periph peri (.i_mclk(i_mclk), .i_strobe(strb),
    .i_buffered_accumulator_level(acb), .o_reg(got));
  assign strb = cmd.cmd[code][k % 3];
  function automatic logic [15:0] step(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0d seen %0d", n, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    i_mclk = 0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Cut a hang short
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  // Fixed codes first, then random codes; every fourth run sends no pulse
  initial begin
    {i_rstn, lng, wrd, acb, tp} = '0;
    repeat (2) @(negedge i_mclk);
    i_rstn = 1;
    for (int i = 0; i < 24; i++) begin
      lf = step(lf);
      code = (i < 8) ? i[5:0] : lf[5:0];
      k = i % 4;
      lng = (i % 5 == 4);
      wid = lng ? ids_pkg::CABLE_LONG_CYC : ids_pkg::CABLE_SHORT_CYC;
      for (int j = 0; j < 160; j++) begin
        mdl_q.push_back((k < 3 && j >= LAT && j < LAT + wid) ? 1 : 0);
      end
      wrd = {lf[15:10], code, lf[9:4]};
      acb = {lf, lf[1:0]};
      repeat (4) @(negedge i_mclk);
      if (k < 3) tp[k] = 1'b1;
      h = 0;
      o = 0;
      for (int j = 0; j < 160; j++) begin
        @(negedge i_mclk);
        if (j == 9) tp = '0;
        chk("model", strb, mdl_q.pop_front());
        h += strb;
        o += $countones(cmd.cmd) - strb + (cmd.cmd_n !== ~cmd.cmd);
      end
      chk("width", h, (k == 3) ? 0 : (lng ? 100 : 40));
      chk("others", o, 0);
      if (k < 3) chk("captured", got, acb);
      $display("test %0d done", i);
    end
    // Reset in mid-pulse clears every command at once; nothing follows release
    code = 6'h2A;
    k = 1;
    lng = 1'b1;
    wrd = {6'h00, code, 6'h00};
    repeat (4) @(negedge i_mclk);
    tp[k] = 1'b1;
    repeat (20) @(negedge i_mclk);
    tp = '0;
    chk("armed", strb, 1);
    i_rstn = 1'b0;
    @(negedge i_mclk);
    chk("reset cmd", $countones(cmd.cmd), 0);
    chk("reset cmd_n", $countones(cmd.cmd_n), ids_pkg::NUM_CODES * ids_pkg::NUM_PULSES);
    @(negedge i_mclk);
    i_rstn = 1'b1;
    o = 0;
    repeat (120) begin
      @(negedge i_mclk);
      o += $countones(cmd.cmd);
    end
    chk("after reset", o, 0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule // ids_decoder_tb
